/* File: bench/burst_sram_assertions.sv */
// port checks for the burst sram core
`timescale 1ns/1ps

module burst_sram_checker (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic dll_disable_n,
   input wire logic [burst_sram_pkg::DATA_WIDTH-1:0] read_data,
   input wire logic read_data_oe,
   input wire logic read_data_valid,
   input wire logic echo_clock_pos,
   input wire logic dll_ready
);
   logic [3:0] still_reg;
   logic [3:0] still_next;
   logic echo_old_reg;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // cycles since the last clock event
   assign still_next = (echo_clock_pos != echo_old_reg) ? 4'h0 :
      (still_reg == 4'hf) ? still_reg : still_reg + 4'h1;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         still_reg <= 4'h0;
         echo_old_reg <= 1'b0;
      end else begin
         still_reg <= still_next;
         echo_old_reg <= echo_clock_pos;
      end
   end
   sequence k_event_s;
      $changed(echo_clock_pos);
   endsequence
   sequence beats_held_s;
      read_data_oe [*4];
   endsequence
   valid_rise_a: assert property ($rose(read_data_valid) |-> k_event_s)
      else $error("valid rose off a clock event");
   valid_fall_a: assert property ($fell(read_data_valid) |-> k_event_s ##0 read_data_oe)
      else $error("valid fell without first beat");
   valid_half_a: assert property ($rose(read_data_valid) |=> read_data_valid [*3])
      else $error("valid too short");
   output_hold_a: assert property (!$changed(echo_clock_pos) |->
      $stable({read_data, read_data_oe, read_data_valid}))
      else $error("read outputs moved between events");
   beat_pair_a: assert property ($rose(read_data_oe) |-> beats_held_s)
      else $error("beat pair cut short");
   lock_wait_a: assert property ($fell(dll_ready) |=> !dll_ready [*8])
      else $error("lock came too soon");
   bypass_ready_a: assert property (!dll_disable_n [*6] |-> dll_ready)
      else $error("bypass not ready");
   disable_reset_a: assert property ($rose(dll_disable_n) |-> ##[2:6] !dll_ready)
      else $error("disable rise kept lock");
   clock_stop_a: assert property (still_reg == 4'hc && dll_disable_n |-> !dll_ready)
      else $error("clock stop kept lock");
endmodule : burst_sram_checker

bind burst_sram_core burst_sram_checker chk (.core_clk(core_clk), .arst_n(arst_n),
   .dll_disable_n(dll_disable_n), .read_data(read_data), .read_data_oe(read_data_oe),
   .read_data_valid(read_data_valid), .echo_clock_pos(echo_clock_pos), .dll_ready(dll_ready));

/* File: bench/k_source.sv */
// input clock source on the host side of the sram core
`timescale 1ns/1ps

module k_source #(
   parameter int half = 6
) (
   input wire logic core_clk,
   input wire logic run,
   output logic k_clk_pin
);
   int cnt;
   // toggles only while run, a stop holds a static level
   initial begin
      k_clk_pin = 1'b0;
      cnt = 0;
      forever begin
         @(negedge core_clk);
         if (run) begin
            cnt = cnt + 1;
            if (cnt == half) begin
               cnt = 0;
               k_clk_pin <= ~k_clk_pin;
            end
         end
      end
   end
endmodule : k_source

/* File: bench/testbench.sv */
// self-checking bench for the burst sram core
`timescale 1ns/1ps

module testbench;
   logic core_clk, arst_n, run, k_clk_pin, dll_disable_n, read_sel_n, write_sel_n;
   logic byte_write_enable0_n, byte_write_enable1_n, read_data_oe, read_data_valid;
   logic echo_clock_pos, echo_clock_neg, dll_ready, pr, pw, prs, pws;
   burst_sram_pkg::addr_type read_addr, write_addr;
   logic [17:0] write_data, read_data;
   logic [17:0] mem [0:15];
   logic [17:0] ed [0:15];
   logic ev [0:15];
   logic eo [0:15];
   logic [31:0] r, q;
   int err_total, samples_checked, seed, h, lat, i;
   localparam int lock_k = 8;

   burst_sram_core #(.fifo_depth(16), .lock_cycles(lock_k)) uut (.core_clk(core_clk),
      .arst_n(arst_n), .k_clk_pin(k_clk_pin), .dll_disable_n(dll_disable_n),
      .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .read_addr(read_addr),
      .write_addr(write_addr), .write_data(write_data),
      .byte_write_enable0_n(byte_write_enable0_n), .byte_write_enable1_n(byte_write_enable1_n),
      .read_data(read_data), .read_data_oe(read_data_oe), .read_data_valid(read_data_valid),
      .echo_clock_pos(echo_clock_pos), .echo_clock_neg(echo_clock_neg), .dll_ready(dll_ready));
   k_source ksrc (.core_clk(core_clk), .run(run), .k_clk_pin(k_clk_pin));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [17:0] seen, input logic [17:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_total++;
         $display("BAD at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check

   function automatic logic [17:0] merge(input logic [17:0] old, input logic [17:0] d,
                                         input logic [1:0] en_n);
      merge = old;
      if (!en_n[0]) merge[8:0] = d[8:0];
      if (!en_n[1]) merge[17:9] = d[17:9];
   endfunction : merge

   // checks the half period that ends at this input clock edge
   task automatic step();
      int s;
      s = h % 16;
      check(read_data_valid, ev[s]);
      check(read_data_oe, eo[s]);
      if (eo[s]) check(read_data, ed[s]);
      check(echo_clock_pos, h % 2 == 0);
      check(echo_clock_neg, h % 2 != 0);
      ev[s] = 1'b0;
      eo[s] = 1'b0;
      h++;
   endtask : step

   task automatic kcyc(input logic rs, input logic ws, input logic [2:0] ra,
                       input logic [2:0] wa, input logic [17:0] d0, input logic [17:0] d1,
                       input logic [1:0] e0, input logic [1:0] e1);
      logic rt, wt;
      @(posedge k_clk_pin);
      step();
      rt = !rs && !pr;
      wt = !ws && !pw && !(!rs && prs && pws);
      if (rt) begin
         ev[(h + lat - 1) % 16] = 1'b1;
         eo[(h + lat) % 16] = 1'b1;
         eo[(h + lat + 1) % 16] = 1'b1;
         ed[(h + lat) % 16] = mem[ra];
         ed[(h + lat + 1) % 16] = mem[ra + 4'h1];
      end
      read_sel_n = rs;
      write_sel_n = ws;
      read_addr = {17'h0, ra};
      write_data = d0;
      {byte_write_enable1_n, byte_write_enable0_n} = e0;
      pr = rt;
      pw = wt;
      prs = rs;
      pws = ws;
      @(negedge k_clk_pin);
      step();
      write_data = d1;
      write_addr = {17'h0, wa};
      {byte_write_enable1_n, byte_write_enable0_n} = e1;
      if (wt) begin
         mem[wa] = merge(mem[wa], d0, e0);
         mem[wa + 4'h1] = merge(mem[wa + 4'h1], d1, e1);
      end
   endtask : kcyc

   task automatic idle(input int n);
      repeat (n) kcyc(1'b1, 1'b1, 3'h0, 3'h0, 18'h0, 18'h0, 2'h3, 2'h3);
   endtask : idle

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   initial begin
      #(700 * 12 * 4);
      err_total++;
      $display("BAD at %0t: run hung", $time);
      complete_run();
   end

   initial begin
      arst_n = 1'b0;
      run = 1'b1;
      dll_disable_n = 1'b0;
      read_sel_n = 1'b1;
      write_sel_n = 1'b1;
      read_addr = '0;
      write_addr = '0;
      write_data = '0;
      byte_write_enable0_n = 1'b1;
      byte_write_enable1_n = 1'b1;
      seed = 98;
      h = 1;
      lat = 2;
      pr = 1'b0;
      pw = 1'b0;
      prs = 1'b1;
      pws = 1'b1;
      err_total = 0;
      samples_checked = 0;
      for (i = 0; i < 16; i++) begin
         ev[i] = 1'b0;
         eo[i] = 1'b0;
      end
      repeat (4) @(negedge core_clk);
      arst_n = 1'b1;
      idle(2);
      check(dll_ready, 1'b1);
      for (i = 0; i < 5; i++) begin
         r = $random(seed);
         kcyc(1'b1, 1'b0, 3'h0, (i == 4) ? 3'h7 : 3'(2 * i), r[17:0], r[31:14], 2'h0, 2'h0);
         idle(1);
      end
      // back-to-back reads, partial lanes, back-to-back write, write after idle
      kcyc(1'b0, 1'b1, 3'h3, 3'h0, 18'h0, 18'h0, 2'h3, 2'h3);
      kcyc(1'b0, 1'b0, 3'h5, 3'h1, 18'h2a5a5, 18'h15a5a, 2'h2, 2'h1);
      kcyc(1'b1, 1'b0, 3'h0, 3'h2, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
      idle(1);
      kcyc(1'b0, 1'b0, 3'h1, 3'h4, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
      idle(1);
      kcyc(1'b1, 1'b0, 3'h0, 3'h5, 18'h1234, 18'h1234, 2'h3, 2'h3);
      idle(2);
      kcyc(1'b0, 1'b1, 3'h4, 3'h0, 18'h0, 18'h0, 2'h3, 2'h3);
      idle(4);
      $display("bypass test done");
      dll_disable_n = 1'b1;
      lat = 4;
      idle(2);
      check(dll_ready, 1'b0);
      idle(lock_k - 3);
      check(dll_ready, 1'b0);
      idle(1);
      check(dll_ready, 1'b1);
      $display("lock test done");
      for (i = 0; i < 300; i++) begin
         r = $random(seed);
         q = $random(seed);
         kcyc(r[0], r[1], r[4:2], r[7:5], q[17:0], q[31:14], r[9:8], r[11:10]);
      end
      $display("random test done");
      idle(4);
      run = 1'b0;
      repeat (20) @(negedge core_clk);
      check(dll_ready, 1'b0);
      run = 1'b1;
      idle(lock_k - 1);
      check(dll_ready, 1'b0);
      idle(1);
      check(dll_ready, 1'b1);
      kcyc(1'b0, 1'b1, 3'h6, 3'h0, 18'h0, 18'h0, 2'h3, 2'h3);
      idle(3);
      $display("clock stop test done");
      complete_run();
   end
endmodule : testbench

/* File: inc/burst_sram_pkg.sv */
// constants, carriers and state types for the burst-of-two sram core
package burst_sram_pkg;
   localparam int DATA_WIDTH = 18;
   localparam int LANE_WIDTH = 9;
   localparam int LANES = 2;
   localparam int ADDR_WIDTH = 20;
   localparam int FIFO_DEPTH = 16;
   localparam int CORE_PERIOD_NS = 4;
   localparam int CLOCK_STOP_NS = 30;
   localparam int CLOCK_STOP_CYCLES = (CLOCK_STOP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   localparam int LOCK_CYCLES = 2048;
   localparam int LAT_NORMAL_HALVES = 4;
   localparam int LAT_BYPASS_HALVES = 2;
   localparam logic [ADDR_WIDTH-1:0] BURST_STEP = 20'h00001;
   localparam logic [1:0] SYNC_RESET = 2'h0;
   localparam logic [1:0] LEVEL_RESET = 2'h0;

   typedef logic [ADDR_WIDTH-1:0] addr_type;

   typedef struct packed {
      logic [DATA_WIDTH-1:0] data;
      logic [LANES-1:0] lane_off_n;
   } write_beat_type;

   typedef enum {dll_bypass, dll_locking, dll_locked} dll_state_type;
endpackage : burst_sram_pkg

/* File: verilog/burst_sram_core.sv */
// burst-of-two ddr sram core: command decode, write buffer, read path, loop control
// How it works
// - pending transfers finish; ports run independently
// - valid leads first beat, drops before last
// - loop disabled gives one-cycle read latency
// - disable rise or stopped clock resets loop
// - lock after 2048 stable input clock cycles
// - second beat address is first plus one
// - read beats at t+2.0 and t+2.5
// - write beats captured at t and t+0.5
// - back-to-back read or write is ignored
// - both selects after idle: read wins
// - per-beat byte enables, all high aborts
// - reads of buffered address return buffer data
`timescale 1ns/1ps

module burst_sram_core #(
   parameter int fifo_depth = burst_sram_pkg::FIFO_DEPTH,
   parameter int lock_cycles = burst_sram_pkg::LOCK_CYCLES
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic k_clk_pin,
   input wire logic dll_disable_n,
   input wire logic read_sel_n,
   input wire logic write_sel_n,
   input wire burst_sram_pkg::addr_type read_addr,
   input wire burst_sram_pkg::addr_type write_addr,
   input wire logic [burst_sram_pkg::DATA_WIDTH-1:0] write_data,
   input wire logic byte_write_enable0_n,
   input wire logic byte_write_enable1_n,
   output logic [burst_sram_pkg::DATA_WIDTH-1:0] read_data,
   output logic read_data_oe,
   output logic read_data_valid,
   output logic echo_clock_pos,
   output logic echo_clock_neg,
   output logic dll_ready
);
   localparam int dw = burst_sram_pkg::DATA_WIDTH;
   localparam int lw = burst_sram_pkg::LANE_WIDTH;
   localparam int ln = burst_sram_pkg::LANES;
   localparam int pipe_len = burst_sram_pkg::LAT_NORMAL_HALVES + 1;
   localparam int stop_cnt_w = $clog2(burst_sram_pkg::CLOCK_STOP_CYCLES + 1);
   localparam logic [stop_cnt_w-1:0] stop_cycles = stop_cnt_w'(burst_sram_pkg::CLOCK_STOP_CYCLES);
   localparam int lock_w = $clog2(lock_cycles + 1);
   localparam logic [lock_w-1:0] lock_last = lock_w'(lock_cycles - 1);

   // per-lane merge of buffered write data over array data
   function automatic logic [dw-1:0] merge_beat(input logic [dw-1:0] base,
                                               input burst_sram_pkg::write_beat_type beat,
                                               input logic hit);
      logic [dw-1:0] result;
      result = base;
      for (int i = 0; i < ln; i++) begin
         if (hit && !beat.lane_off_n[i]) begin
            result[i*lw +: lw] = beat.data[i*lw +: lw];
         end
      end
      return result;
   endfunction : merge_beat

   // pin synchronisers: bit 0 input clock, bit 1 loop disable
   logic [1:0] sync_a_reg;
   logic [1:0] sync_b_reg;
   logic [1:0] sync_c_reg;
   logic [1:0] level_reg;
   wire [1:0] agree = ~(sync_b_reg ^ sync_c_reg);
   wire [1:0] level_next = (agree & sync_c_reg) | (~agree & level_reg);
   wire k_rise = level_next[0] && !level_reg[0];
   wire k_fall = !level_next[0] && level_reg[0];
   wire k_event = k_rise || k_fall;
   wire dis_rise = level_next[1] && !level_reg[1];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_a_reg <= burst_sram_pkg::SYNC_RESET;
         sync_b_reg <= burst_sram_pkg::SYNC_RESET;
         sync_c_reg <= burst_sram_pkg::SYNC_RESET;
         level_reg <= burst_sram_pkg::LEVEL_RESET;
      end else begin
         sync_a_reg <= {dll_disable_n, k_clk_pin};
         sync_b_reg <= sync_a_reg;
         sync_c_reg <= sync_b_reg;
         level_reg <= level_next;
      end
   end

   // clock stop detection and loop state
   logic [stop_cnt_w-1:0] stop_cnt_reg;
   logic [lock_w-1:0] lock_cnt_reg;
   burst_sram_pkg::dll_state_type dll_state_reg;
   burst_sram_pkg::dll_state_type dll_state_next;
   wire stop_hit = !k_event && (stop_cnt_reg == stop_cycles - 1'b1);
   wire dll_reset = dis_rise || stop_hit;
   wire bypass = (dll_state_reg == burst_sram_pkg::dll_bypass);

   always_comb begin
      dll_state_next = dll_state_reg;
      case (dll_state_reg)
         burst_sram_pkg::dll_bypass: begin
            if (dis_rise) dll_state_next = burst_sram_pkg::dll_locking;
         end
         burst_sram_pkg::dll_locking: begin
            if (k_rise && lock_cnt_reg == lock_last) dll_state_next = burst_sram_pkg::dll_locked;
         end
         burst_sram_pkg::dll_locked: begin
            if (dll_reset) dll_state_next = burst_sram_pkg::dll_locking;
         end
         default: dll_state_next = burst_sram_pkg::dll_bypass;
      endcase
      if (!level_next[1]) dll_state_next = burst_sram_pkg::dll_bypass;
      else if (dll_reset) dll_state_next = burst_sram_pkg::dll_locking;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         stop_cnt_reg <= '0;
         lock_cnt_reg <= '0;
         dll_state_reg <= burst_sram_pkg::dll_bypass;
         dll_ready <= 1'b0;
      end else begin
         if (k_event) stop_cnt_reg <= '0;
         else if (stop_cnt_reg != stop_cycles) stop_cnt_reg <= stop_cnt_reg + 1'b1;
         if (dll_state_next != burst_sram_pkg::dll_locking || dll_reset) lock_cnt_reg <= '0;
         else if (k_rise) lock_cnt_reg <= lock_cnt_reg + 1'b1;
         dll_state_reg <= dll_state_next;
         dll_ready <= (dll_state_next != burst_sram_pkg::dll_locking);
      end
   end

   // command decode on the input clock rise
   logic rd_prev_reg;
   logic wr_prev_reg;
   logic idle_prev_reg;
   wire rd_acc = k_rise && !read_sel_n && !rd_prev_reg;
   wire both_after_idle = !read_sel_n && !write_sel_n && idle_prev_reg;
   wire wr_acc = k_rise && !write_sel_n && !wr_prev_reg && !both_after_idle;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_prev_reg <= 1'b0;
         wr_prev_reg <= 1'b0;
         idle_prev_reg <= 1'b1;
      end else if (k_rise) begin
         rd_prev_reg <= rd_acc;
         wr_prev_reg <= wr_acc;
         idle_prev_reg <= read_sel_n && write_sel_n;
      end
   end

   // write collection, buffer and commit
   logic collecting_reg;
   burst_sram_pkg::write_beat_type first_beat_reg;
   logic buf_valid_reg;
   burst_sram_pkg::addr_type buf_addr_reg;
   burst_sram_pkg::write_beat_type buf_beat_reg [0:1];
   logic [1:0] commit_reg;
   wire [ln-1:0] bw_n = {byte_write_enable1_n, byte_write_enable0_n};
   wire commit_beat = commit_reg[1];
   wire commit_active = commit_reg != 2'h0;
   wire burst_sram_pkg::addr_type commit_addr = buf_addr_reg + (commit_beat ? 
      burst_sram_pkg::BURST_STEP : '0);
   wire burst_sram_pkg::write_beat_type commit_data = buf_beat_reg[commit_beat];
   wire ram_wr_en = commit_active && (commit_data.lane_off_n != '1);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         collecting_reg <= 1'b0;
         first_beat_reg <= '0;
         buf_valid_reg <= 1'b0;
         buf_addr_reg <= '0;
         buf_beat_reg[0] <= '0;
         buf_beat_reg[1] <= '0;
         commit_reg <= 2'h0;
      end else begin
         if (wr_acc) begin
            first_beat_reg <= '{data: write_data, lane_off_n: bw_n};
            collecting_reg <= 1'b1;
         end else if (k_fall && collecting_reg) begin
            buf_addr_reg <= write_addr;
            buf_beat_reg[0] <= first_beat_reg;
            buf_beat_reg[1] <= '{data: write_data, lane_off_n: bw_n};
            buf_valid_reg <= 1'b1;
            collecting_reg <= 1'b0;
         end
         if (wr_acc && buf_valid_reg) commit_reg <= 2'h1;
         else if (commit_reg == 2'h1) commit_reg <= 2'h2;
         else commit_reg <= 2'h0;
      end
   end

   // read fetch: array read, buffer merge, push into output fifo
   logic fetch_pend_reg;
   burst_sram_pkg::addr_type fetch_addr_reg;
   logic fetch_beat_reg;
   logic b_valid_reg;
   burst_sram_pkg::addr_type b_addr_reg;
   logic [dw-1:0] ram_rd_data;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [dw-1:0] fifo_out_data;
   wire fetch_issue = fetch_pend_reg && fifo_in_ready && !b_valid_reg;
   wire burst_sram_pkg::addr_type ram_rd_addr = fetch_addr_reg + (fetch_beat_reg ? 
      burst_sram_pkg::BURST_STEP : '0);
   wire hit0 = buf_valid_reg && (b_addr_reg == buf_addr_reg);
   wire hit1 = buf_valid_reg && (b_addr_reg == buf_addr_reg + burst_sram_pkg::BURST_STEP);
   wire [dw-1:0] fwd_data = merge_beat(merge_beat(ram_rd_data, buf_beat_reg[0], hit0),
                                       buf_beat_reg[1], hit1);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_pend_reg <= 1'b0;
         fetch_addr_reg <= '0;
         fetch_beat_reg <= 1'b0;
         b_valid_reg <= 1'b0;
         b_addr_reg <= '0;
      end else begin
         if (rd_acc) begin
            fetch_pend_reg <= 1'b1;
            fetch_addr_reg <= read_addr;
            fetch_beat_reg <= 1'b0;
         end else if (fetch_issue) begin
            fetch_pend_reg <= !fetch_beat_reg;
            fetch_beat_reg <= 1'b1;
         end
         b_valid_reg <= fetch_issue;
         if (fetch_issue) b_addr_reg <= ram_rd_addr;
      end
   end

   sram_array #(
      .addr_width(burst_sram_pkg::ADDR_WIDTH),
      .lanes(ln),
      .lane_width(lw)
   ) array_inst (
      .clk(core_clk),
      .arst_n(arst_n),
      .wr_en(ram_wr_en),
      .wr_addr(commit_addr),
      .wr_lane_en(~commit_data.lane_off_n),
      .wr_data(commit_data.data),
      .rd_addr(ram_rd_addr),
      .rd_data(ram_rd_data)
   );

   // read output timing in half cycles of the input clock
   logic [pipe_len-1:0] rd_pipe_reg;
   wire due0 = bypass ? rd_pipe_reg[burst_sram_pkg::LAT_BYPASS_HALVES - 1] :
                        rd_pipe_reg[burst_sram_pkg::LAT_NORMAL_HALVES - 1];
   wire due1 = bypass ? rd_pipe_reg[burst_sram_pkg::LAT_BYPASS_HALVES] :
                        rd_pipe_reg[burst_sram_pkg::LAT_NORMAL_HALVES];
   wire pre_first = bypass ? rd_pipe_reg[burst_sram_pkg::LAT_BYPASS_HALVES - 2] :
                             rd_pipe_reg[burst_sram_pkg::LAT_NORMAL_HALVES - 2];
   wire beat_out = k_event && (due0 || due1) && fifo_out_valid;

   sync_fifo #(
      .width(dw),
      .depth(fifo_depth)
   ) read_fifo_inst (
      .clk(core_clk),
      .arst_n(arst_n),
      .in_valid(b_valid_reg),
      .in_ready(fifo_in_ready),
      .in_data(fwd_data),
      .out_valid(fifo_out_valid),
      .out_ready(beat_out),
      .out_data(fifo_out_data)
   );

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_pipe_reg <= '0;
         read_data <= '0;
         read_data_oe <= 1'b0;
         read_data_valid <= 1'b0;
         echo_clock_pos <= 1'b0;
         echo_clock_neg <= 1'b1;
      end else if (k_event) begin
         rd_pipe_reg <= {rd_pipe_reg[pipe_len-2:0], rd_acc};
         read_data_oe <= beat_out;
         if (beat_out) read_data <= fifo_out_data;
         read_data_valid <= pre_first;
         echo_clock_pos <= k_rise;
         echo_clock_neg <= k_fall;
      end
   end
endmodule : burst_sram_core

/* File: verilog/store_blocks.sv */
// byte-lane memory array and a show-ahead fifo with registered read data
`timescale 1ns/1ps

module sram_array #(
   parameter int addr_width = burst_sram_pkg::ADDR_WIDTH,
   parameter int lanes = burst_sram_pkg::LANES,
   parameter int lane_width = burst_sram_pkg::LANE_WIDTH
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [addr_width-1:0] wr_addr,
   input wire logic [lanes-1:0] wr_lane_en,
   input wire logic [lanes*lane_width-1:0] wr_data,
   input wire logic [addr_width-1:0] rd_addr,
   output logic [lanes*lane_width-1:0] rd_data
);
   logic [lanes*lane_width-1:0] mem [0:(1 << addr_width)-1];

   always_ff @(posedge clk) begin
      for (int i = 0; i < lanes; i++) begin
         if (wr_en && wr_lane_en[i]) begin
            mem[wr_addr][i*lane_width +: lane_width] <= wr_data[i*lane_width +: lane_width];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : sram_array

module sync_fifo #(
   parameter int width = burst_sram_pkg::DATA_WIDTH,
   parameter int depth = burst_sram_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [width-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [width-1:0] out_data
);
   localparam int pw = $clog2(depth);
   logic [width-1:0] mem [0:depth-1];
   logic [pw-1:0] wr_ptr_reg;
   logic [pw-1:0] rd_ptr_reg;
   logic [pw:0] count_reg;
   logic out_valid_reg;
   logic [width-1:0] out_data_reg;
   wire push = in_valid && in_ready;
   wire load = (count_reg != '0) && (!out_valid_reg || out_ready);
   wire [pw-1:0] wr_ptr_next = (wr_ptr_reg == pw'(depth - 1)) ? '0 : wr_ptr_reg + 1'b1;
   wire [pw-1:0] rd_ptr_next = (rd_ptr_reg == pw'(depth - 1)) ? '0 : rd_ptr_reg + 1'b1;

   assign in_ready = (count_reg != (pw + 1)'(depth));
   assign out_valid = out_valid_reg;
   assign out_data = out_data_reg;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_next;
         if (load) rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_reg + (pw + 1)'(push) - (pw + 1)'(load);
         out_valid_reg <= load || (out_valid_reg && !out_ready);
         if (load) out_data_reg <= mem[rd_ptr_reg];
      end
   end
endmodule : sync_fifo
